// file: src/hsic_phy_signal_timing.v
// HSIC physical layer signal timing: wakeup drive, chirp answer, bus reset filter
//
// Functional notes
// RULE1: Drive remote wakeup at least programmed microseconds
// RULE2: Wakeup time: 16 bits, bytes 0x208/0x209
// RULE3: Wait turnaround count after engine chirp K
// RULE4: Chirp answer alternates K and J, starting K
// RULE5: Each K or J lasts bit-period count
// RULE6: Bus reset recognised after filter; entry only
// RULE7: Filter high byte at 0x215, resets zero
// RULE8: Microsecond step from divided clock; load at start
`timescale 1ns/1ps
`include "hsic_timing_consts.vh"
module hsic_phy_signal_timing #(
   parameter CHIRP_PAIRS = `CHIRP_PAIRS
) (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire hreadyout_o,
   output wire hresp_o,
   output wire [31:0] hrdata_o,
   input wire strobe_i,
   output wire strobe_o,
   output wire strobe_oe_n_o,
   input wire data_i,
   output wire data_o,
   output wire data_oe_n_o,
   input wire engine_wake_i,
   input wire engine_chirp_k_i,
   output wire chirp_k_o,
   output wire chirp_j_o,
   output wire bus_reset_o,
   output wire wake_active_o
);
   localparam integer UPC_N = `UNITS_PER_CLK;
   localparam integer STEP_N = `CYC_PER_STEP - 1;
   localparam integer BIT_N = 2 * CHIRP_PAIRS - 1;
   localparam [15:0] UPC = UPC_N[15:0];
   localparam [3:0] STEP_LAST = STEP_N[3:0];
   localparam [7:0] BIT_LAST = BIT_N[7:0];

   localparam [1:0] C_IDLE = 2'h0;
   localparam [1:0] C_TURN = 2'h1;
   localparam [1:0] C_BIT = 2'h2;
   localparam [1:0] C_DONE = 2'h3;

   // Counts are in 60 MHz periods; each system clock covers several of them
   function [15:0] tick_down;
      input [15:0] v;
      begin
         tick_down = (v > UPC) ? (v - UPC) : 16'h0000;
      end
   endfunction

   function last_tick;
      input [15:0] v;
      begin
         last_tick = (v <= UPC);
      end
   endfunction

   // Register file
   reg [7:0] wake_lo_r;
   reg [7:0] wake_hi_r;
   reg [7:0] turn_lo_r;
   reg [7:0] turn_hi_r;
   reg [7:0] bit_lo_r;
   reg [7:0] bit_hi_r;
   reg [7:0] filt_lo_r;
   reg [7:0] filt_hi_r;

   wire [`IDX_W-1:0] rd_idx;
   wire [`IDX_W-1:0] wr_idx;
   wire [7:0] wr_byte;
   wire wr;
   reg [7:0] rd_byte;
   reg rd_hit;

   // Link synchronisers and state
   reg strobe_s1_r;
   reg strobe_s2_r;
   reg strobe_d_r;
   reg data_s1_r;
   reg data_s2_r;
   wire strobe_edge;
   wire reset_state;

   reg [15:0] filt_cnt_r;
   reg filt_run_r;
   reg bus_reset_r;

   reg [15:0] wake_cnt_r;
   reg [3:0] step_r;
   reg wake_r;
   reg req_d_r;

   reg [1:0] cst_r;
   reg [15:0] crem_r;
   reg [7:0] cbit_r;
   reg chirp_k_r;
   reg chirp_j_r;
   reg ck_d_r;

   ahb_byte_port #(
      .ADDR_W(14)
   ) u_port (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hwdata_i(hwdata_i),
      .hready_i(hready_i),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .hrdata_o(hrdata_o),
      .rd_idx_o(rd_idx),
      .rd_byte_i(rd_byte),
      .rd_hit_i(rd_hit),
      .wr_o(wr),
      .wr_idx_o(wr_idx),
      .wr_byte_o(wr_byte)
   );

   // Read decode
   always @* begin
      rd_hit = 1'b1;
      case (rd_idx)
         `IDX_WAKE_LO: rd_byte = wake_lo_r; // [RULE2]
         `IDX_WAKE_HI: rd_byte = wake_hi_r; // [RULE2]
         `IDX_TURN_LO: rd_byte = turn_lo_r;
         `IDX_TURN_HI: rd_byte = turn_hi_r;
         `IDX_BIT_LO: rd_byte = bit_lo_r;
         `IDX_BIT_HI: rd_byte = bit_hi_r;
         `IDX_FILT_LO: rd_byte = filt_lo_r;
         `IDX_FILT_HI: rd_byte = filt_hi_r; // [RULE7]
         `IDX_STATUS: begin
            rd_byte = 8'h00;
            rd_byte[`ST_BUS_RESET] = bus_reset_r;
            rd_byte[`ST_WAKE] = wake_r;
            rd_byte[`ST_CHIRP] = (cst_r == C_TURN) | (cst_r == C_BIT);
            rd_byte[`ST_STROBE] = strobe_s2_r;
            rd_byte[`ST_DATA] = data_s2_r;
         end
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Register writes; the status register ignores writes
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wake_lo_r <= `RST_WAKE_LO;
         wake_hi_r <= `RST_WAKE_HI;
         turn_lo_r <= `RST_TURN_LO;
         turn_hi_r <= `RST_TURN_HI;
         bit_lo_r <= `RST_BIT_LO;
         bit_hi_r <= `RST_BIT_HI;
         filt_lo_r <= `RST_FILT_LO;
         filt_hi_r <= `RST_FILT_HI; // [RULE7]
      end else if (wr) begin
         case (wr_idx)
            `IDX_WAKE_LO: wake_lo_r <= wr_byte; // [RULE2]
            `IDX_WAKE_HI: wake_hi_r <= wr_byte; // [RULE2]
            `IDX_TURN_LO: turn_lo_r <= wr_byte;
            `IDX_TURN_HI: turn_hi_r <= wr_byte;
            `IDX_BIT_LO: bit_lo_r <= wr_byte;
            `IDX_BIT_HI: bit_hi_r <= wr_byte;
            `IDX_FILT_LO: filt_lo_r <= wr_byte;
            `IDX_FILT_HI: filt_hi_r <= wr_byte; // [RULE7]
            default: ;
         endcase
      end
   end

   // Link pins come from the far side; two flops before anything looks at them
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         strobe_s1_r <= 1'b1;
         strobe_s2_r <= 1'b1;
         strobe_d_r <= 1'b1;
         data_s1_r <= 1'b0;
         data_s2_r <= 1'b0;
      end else begin
         strobe_s1_r <= strobe_i;
         strobe_s2_r <= strobe_s1_r;
         strobe_d_r <= strobe_s2_r;
         data_s1_r <= data_i;
         data_s2_r <= data_s1_r;
      end
   end

   assign strobe_edge = strobe_s2_r ^ strobe_d_r;
   // Reset bus state: both lines held low and the strobe not toggling
   assign reset_state = ~strobe_s2_r & ~data_s2_r & ~strobe_edge;

   // Reset filter: qualifies entry only, exit is immediate
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         filt_cnt_r <= 16'h0000;
         filt_run_r <= 1'b0;
         bus_reset_r <= 1'b0;
      end else if (~reset_state) begin
         filt_run_r <= 1'b0;
         bus_reset_r <= 1'b0; // [RULE6]
      end else if (~filt_run_r & ~bus_reset_r) begin
         filt_cnt_r <= tick_down({filt_hi_r, filt_lo_r}); // [RULE6]
         filt_run_r <= ~last_tick({filt_hi_r, filt_lo_r});
         bus_reset_r <= last_tick({filt_hi_r, filt_lo_r});
      end else if (filt_run_r) begin
         filt_cnt_r <= tick_down(filt_cnt_r);
         if (last_tick(filt_cnt_r)) begin
            filt_run_r <= 1'b0;
            bus_reset_r <= 1'b1; // [RULE6]
         end
      end
   end

   // Remote wakeup: the engine's request may be shorter than the minimum time
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         wake_cnt_r <= 16'h0000;
         step_r <= 4'h0;
         wake_r <= 1'b0;
         req_d_r <= 1'b0;
      end else begin
         req_d_r <= engine_wake_i;
         if (engine_wake_i & ~req_d_r & ~wake_r) begin
            wake_cnt_r <= {wake_hi_r, wake_lo_r}; // [RULE8]
            step_r <= 4'h0;
            wake_r <= 1'b1;
         end else if (wake_r) begin
            // One microsecond per divided step
            if (step_r == STEP_LAST) begin
               step_r <= 4'h0; // [RULE8]
               if (wake_cnt_r != 16'h0000) begin
                  wake_cnt_r <= wake_cnt_r - 16'h0001;
               end
            end else begin
               step_r <= step_r + 4'h1;
            end
            // A last step only ends the drive once the request is gone
            if (~engine_wake_i & ((wake_cnt_r == 16'h0000) |
                ((wake_cnt_r == 16'h0001) & (step_r == STEP_LAST)))) begin
               wake_r <= 1'b0; // [RULE1]
            end
         end
      end
   end

   // Wakeup drives strobe low and data high; released otherwise
   assign strobe_o = 1'b0;
   assign data_o = 1'b1;
   assign strobe_oe_n_o = ~wake_r; // [RULE1]
   assign data_oe_n_o = ~wake_r; // [RULE1]
   assign wake_active_o = wake_r;
   assign bus_reset_o = bus_reset_r;

   // Chirp answer toward the engine
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cst_r <= C_IDLE;
         crem_r <= 16'h0000;
         cbit_r <= 8'h00;
         chirp_k_r <= 1'b0;
         chirp_j_r <= 1'b0;
         ck_d_r <= 1'b0;
      end else begin
         ck_d_r <= engine_chirp_k_i;
         case (cst_r)
            C_IDLE: begin
               chirp_k_r <= 1'b0;
               chirp_j_r <= 1'b0;
               if (engine_chirp_k_i & ~ck_d_r) begin
                  crem_r <= {turn_hi_r, turn_lo_r}; // [RULE3]
                  cst_r <= C_TURN;
               end
            end
            C_TURN: begin
               // The engine dropping its K before turnaround cancels the answer
               if (~engine_chirp_k_i & (crem_r > UPC)) begin
                  cst_r <= C_IDLE;
               end else if (last_tick(crem_r)) begin
                  cst_r <= C_BIT; // [RULE3]
                  crem_r <= {bit_hi_r, bit_lo_r};
                  cbit_r <= 8'h00;
                  chirp_k_r <= 1'b1; // [RULE4]
                  chirp_j_r <= 1'b0;
               end else begin
                  crem_r <= tick_down(crem_r); // [RULE3]
               end
            end
            C_BIT: begin
               if (last_tick(crem_r)) begin
                  crem_r <= {bit_hi_r, bit_lo_r}; // [RULE5]
                  if (cbit_r == BIT_LAST) begin
                     cst_r <= C_DONE;
                     chirp_k_r <= 1'b0;
                     chirp_j_r <= 1'b0;
                  end else begin
                     cbit_r <= cbit_r + 8'h01;
                     chirp_k_r <= cbit_r[0]; // [RULE4]
                     chirp_j_r <= ~cbit_r[0]; // [RULE4]
                  end
               end else begin
                  crem_r <= tick_down(crem_r); // [RULE5]
               end
            end
            C_DONE: begin
               // Wait for the engine to release its K before rearming
               if (~engine_chirp_k_i) begin
                  cst_r <= C_IDLE;
               end
            end
            default: cst_r <= C_IDLE;
         endcase
      end
   end

   assign chirp_k_o = chirp_k_r;
   assign chirp_j_o = chirp_j_r;
endmodule // hsic_phy_signal_timing

// file: src/hsic_timing_consts.vh
// Constants for the HSIC signal timing block: register indices, resets, timing units
`ifndef HSIC_TIMING_CONSTS_VH
`define HSIC_TIMING_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_W 12
`define IDX_WAKE_LO 12'h208
`define IDX_WAKE_HI 12'h209
`define IDX_TURN_LO 12'h20C
`define IDX_TURN_HI 12'h20D
`define IDX_BIT_LO 12'h210
`define IDX_BIT_HI 12'h211
`define IDX_FILT_LO 12'h214
`define IDX_FILT_HI 12'h215
`define IDX_STATUS 12'h220

// Reset values
`define RST_WAKE_LO 8'hE8
`define RST_WAKE_HI 8'h03
`define RST_TURN_LO 8'h58
`define RST_TURN_HI 8'h02
`define RST_BIT_LO 8'hB9
`define RST_BIT_HI 8'h0B
`define RST_FILT_LO 8'hB4
`define RST_FILT_HI 8'h00

// Status register bit positions
`define ST_BUS_RESET 0
`define ST_WAKE 1
`define ST_CHIRP 2
`define ST_STROBE 3
`define ST_DATA 4

// Timing: system clock, count unit clock, wakeup step
`define CLK_FREQ_KHZ 10000
`define UNIT_FREQ_KHZ 60000
`define STEP_TIME_US 1
`define UNITS_PER_CLK (`UNIT_FREQ_KHZ / `CLK_FREQ_KHZ)
`define CYC_PER_STEP ((`STEP_TIME_US * `CLK_FREQ_KHZ) / 1000)

// Number of K/J pairs in the chirp answer
`define CHIRP_PAIRS 3

`endif

// file: src/ahb_byte_port.v
// AHB-Lite slave front end carrying byte-wide registers, one per aligned word
`timescale 1ns/1ps
`include "hsic_timing_consts.vh"
module ahb_byte_port #(
   parameter ADDR_W = 14
) (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output wire hreadyout_o,
   output wire hresp_o,
   output wire [31:0] hrdata_o,
   output wire [`IDX_W-1:0] rd_idx_o,
   input wire [7:0] rd_byte_i,
   input wire rd_hit_i,
   output wire wr_o,
   output wire [`IDX_W-1:0] wr_idx_o,
   output wire [7:0] wr_byte_o
);
   reg [31:0] hrdata_r;
   reg wr_pend_r;
   reg [`IDX_W-1:0] wr_idx_r;
   wire take;
   wire addr_ok;

   // Only word-sized, aligned accesses inside the map are decoded
   assign take = hsel_i & htrans_i[1] & hready_i;
   assign addr_ok = (haddr_i[31:ADDR_W] == {(32-ADDR_W){1'b0}}) & (haddr_i[1:0] == 2'h0) & (hsize_i == 3'h2);
   assign rd_idx_o = haddr_i[ADDR_W-1:2];

   // Zero wait states; every answer is OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_r;
   assign wr_o = wr_pend_r;
   assign wr_idx_o = wr_idx_r;
   assign wr_byte_o = hwdata_i[7:0];

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hrdata_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_idx_r <= {`IDX_W{1'b0}};
      end else begin
         wr_pend_r <= take & hwrite_i & addr_ok;
         if (take) begin
            wr_idx_r <= haddr_i[ADDR_W-1:2];
         end
         // Read data sampled in the address phase; unmapped reads return zero
         if (take & ~hwrite_i) begin
            hrdata_r <= {24'h00_0000, (addr_ok & rd_hit_i) ? rd_byte_i : 8'h00};
         end
      end
   end
endmodule // ahb_byte_port

// file: sim/hsic_timing_properties.sv
// Assertion checker for the HSIC signal timing block
`timescale 1ns/1ps
module hsic_timing_properties (
   input wire mclk_i,
   input wire sys_rst_i,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire [31:0] hrdata_o,
   input wire strobe_i,
   input wire data_i,
   input wire strobe_oe_n_o,
   input wire data_oe_n_o,
   input wire engine_wake_i,
   input wire engine_chirp_k_i,
   input wire chirp_k_o,
   input wire chirp_j_o,
   input wire bus_reset_o,
   input wire wake_active_o
);
   wire lines_low = !strobe_i && !data_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   property p_bus; hreadyout_o && !hresp_o && hrdata_o[31:8] == 24'h000000; endproperty
   a_bus: assert property (p_bus) else $error("bus answer wrong");
   property p_wk_go; $rose(engine_wake_i) && !wake_active_o |=> wake_active_o; endproperty
   a_wk_go: assert property (p_wk_go) else $error("wakeup not started");
   property p_wk_oe; wake_active_o == (!strobe_oe_n_o && !data_oe_n_o); endproperty
   a_wk_oe: assert property (p_wk_oe) else $error("wakeup enables wrong");
   property p_wk_end; $fell(wake_active_o) |-> !$past(engine_wake_i); endproperty
   a_wk_end: assert property (p_wk_end) else $error("wakeup cut short");
   property p_ch_ex; !(chirp_k_o && chirp_j_o); endproperty
   a_ch_ex: assert property (p_ch_ex) else $error("K and J together");
   property p_ch_j; $rose(chirp_j_o) |-> $fell(chirp_k_o); endproperty
   a_ch_j: assert property (p_ch_j) else $error("J not after K");
   // The first K must trail the engine's K by at least the register stage
   property p_ch_go; $rose(chirp_k_o) && !$past(chirp_j_o) |-> $past(engine_chirp_k_i, 2); endproperty
   a_ch_go: assert property (p_ch_go) else $error("chirp without engine K");
   // Three samples back is the newest point at which both pins must already have been low
   property p_rs_in; $rose(bus_reset_o) |-> $past(lines_low, 3); endproperty
   a_rs_in: assert property (p_rs_in) else $error("bus reset unfiltered");
   property p_rs_out; !lines_low |-> ##[1:4] !bus_reset_o; endproperty
   a_rs_out: assert property (p_rs_out) else $error("bus reset stuck");
   c_wk: cover property ($rose(wake_active_o));
   c_ch: cover property ($fell(chirp_j_o));
   c_rs: cover property ($rose(bus_reset_o));
endmodule // hsic_timing_properties
bind hsic_phy_signal_timing hsic_timing_properties chk_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .strobe_i(strobe_i), .data_i(data_i),
   .strobe_oe_n_o(strobe_oe_n_o), .data_oe_n_o(data_oe_n_o), .engine_wake_i(engine_wake_i),
   .engine_chirp_k_i(engine_chirp_k_i), .chirp_k_o(chirp_k_o), .chirp_j_o(chirp_j_o), .bus_reset_o(bus_reset_o),
   .wake_active_o(wake_active_o));

// file: sim/hsic_host_model.sv
// Far-side HSIC host model driving the strobe and data lines
`timescale 1ns/1ps
module hsic_host_model (
   input wire [1:0] mode_i,
   output wire strobe_o,
   output wire data_o
);
   logic lclk = 1'b0;
   logic frame_data = 1'b0;
   initial begin
      #137;
      forever #400 lclk = ~lclk;
   end
   always @(posedge lclk) begin
      frame_data <= ~frame_data;
   end
   // Strobe stands still outside frames; mode 2 holds both lines low (reset state)
   assign strobe_o = (mode_i == 2'h1) ? lclk : (mode_i == 2'h0);
   assign data_o = (mode_i == 2'h1) ? frame_data : 1'b0;
endmodule // hsic_host_model

// file: sim/tb_top.sv
// Testbench for the HSIC signal timing block
`timescale 1ns/1ps
`include "hsic_timing_consts.vh"
module tb_top;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h00000000;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h00000000;
   logic engine_wake_i = 1'b0;
   logic engine_chirp_k_i = 1'b0;
   logic [1:0] host_mode = 2'h0;
   wire hreadyout_o, hresp_o, strobe_o, strobe_oe_n_o, data_o, data_oe_n_o;
   wire chirp_k_o, chirp_j_o, bus_reset_o, wake_active_o, host_strobe, host_data;
   wire [31:0] hrdata_o;
   wire strobe_w = strobe_oe_n_o ? host_strobe : strobe_o;
   wire data_w = data_oe_n_o ? host_data : data_o;
   int err_count = 0;
   int check_count = 0;
   int n;
   int i;
   logic [31:0] rd;
   logic [19:0] rows [8] = '{{`IDX_WAKE_LO, `RST_WAKE_LO}, {`IDX_WAKE_HI, `RST_WAKE_HI},
      {`IDX_TURN_LO, `RST_TURN_LO}, {`IDX_TURN_HI, `RST_TURN_HI}, {`IDX_BIT_LO, `RST_BIT_LO},
      {`IDX_BIT_HI, `RST_BIT_HI}, {`IDX_FILT_LO, `RST_FILT_LO}, {`IDX_FILT_HI, `RST_FILT_HI}};
   // Short timings: wake 2 us, turnaround 12, bit 30, filter 60 units
   logic [7:0] tval [8] = '{8'h02, 8'h00, 8'h0C, 8'h00, 8'h1E, 8'h00, 8'h3C, 8'h00};
   hsic_phy_signal_timing dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .strobe_i(strobe_w),
      .strobe_o(strobe_o), .strobe_oe_n_o(strobe_oe_n_o), .data_i(data_w), .data_o(data_o),
      .data_oe_n_o(data_oe_n_o), .engine_wake_i(engine_wake_i), .engine_chirp_k_i(engine_chirp_k_i),
      .chirp_k_o(chirp_k_o), .chirp_j_o(chirp_j_o), .bus_reset_o(bus_reset_o), .wake_active_o(wake_active_o));
   hsic_host_model host_u (.mode_i(host_mode), .strobe_o(host_strobe), .data_o(host_data));
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] ba(input logic [11:0] idx);
      return {18'h00000, idx, 2'h0};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) @(posedge mclk_i);
      rd = hrdata_o;
   endtask
   task automatic stop_test;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(4000 * 100);
      err_count++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (i = 0; i < 8; i++) begin
         xfer(1'b0, ba(rows[i][19:8]), 32'h00000000);
         chk(rd, {24'h000000, rows[i][7:0]});
         xfer(1'b1, ba(rows[i][19:8]), {24'h000000, ~rows[i][7:0]});
         xfer(1'b0, ba(rows[i][19:8]), 32'h00000000);
         chk(rd, {24'h000000, ~rows[i][7:0]});
         xfer(1'b1, ba(rows[i][19:8]), {24'h000000, tval[i]});
      end
      xfer(1'b1, 32'h00000884, 32'h000000FF);
      xfer(1'b0, 32'h00000884, 32'h00000000);
      chk(rd, 32'h00000000);
      xfer(1'b0, 32'h00000821, 32'h00000000);
      chk(rd, 32'h00000000);
      // Short request: the 2 us minimum holds; long request: drive follows it
      for (i = 0; i < 2; i++) begin
         engine_wake_i <= 1'b1;
         repeat (i ? 40 : 1) @(posedge mclk_i);
         engine_wake_i <= 1'b0;
         @(posedge mclk_i);
         chk(strobe_w, 1'b0);
         chk(data_w, 1'b1);
         n = 0;
         while (wake_active_o === 1'b1 && n < 100) begin
            n++;
            @(posedge mclk_i);
         end
         chk(32'(i ? n <= 2 : (n >= 19 && n <= 22)), 32'h1);
      end
      engine_chirp_k_i <= 1'b1;
      n = 0;
      @(posedge mclk_i);
      while (chirp_k_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge mclk_i);
      end
      chk(32'(n >= 3 && n <= 4), 32'h1);
      for (i = 0; i < 6; i++) begin
         n = 0;
         while ({chirp_k_o, chirp_j_o} === (i[0] ? 2'b01 : 2'b10) && n < 20) begin
            n++;
            @(posedge mclk_i);
         end
         chk(n, 5);
      end
      chk({chirp_k_o, chirp_j_o}, 2'b00);
      engine_chirp_k_i <= 1'b0;
      // A strobe edge part way through must restart the filter
      host_mode <= 2'h2;
      repeat (8) @(posedge mclk_i);
      host_mode <= 2'h1;
      repeat (10) @(posedge mclk_i);
      host_mode <= 2'h2;
      repeat (10) @(posedge mclk_i);
      chk(bus_reset_o, 1'b0);
      repeat (6) @(posedge mclk_i);
      chk(bus_reset_o, 1'b1);
      xfer(1'b0, ba(`IDX_STATUS), 32'h00000000);
      chk(rd, 32'h1 << `ST_BUS_RESET);
      host_mode <= 2'h0;
      repeat (4) @(posedge mclk_i);
      chk(bus_reset_o, 1'b0);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      xfer(1'b0, ba(`IDX_WAKE_LO), 32'h00000000);
      chk(rd, {24'h000000, `RST_WAKE_LO});
      stop_test;
   end
endmodule // tb_top
